// file: inc/ccc_pkg.sv
package ccc_pkg;

  // Source index order shared by every per-source vector
  localparam int unsigned NSRC = 6;
  localparam logic [2:0] SRC_FAST_XTAL = 3'h0;
  localparam logic [2:0] SRC_SLOW_XTAL = 3'h1;
  localparam logic [2:0] SRC_MULT = 3'h2;
  localparam logic [2:0] SRC_SLOW_RC = 3'h3;
  localparam logic [2:0] SRC_RC22 = 3'h4;
  localparam logic [2:0] SRC_RC48 = 3'h5;

  localparam int unsigned CNT_W = 14;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned WD_W = 11;

  // Stable counts in cycles of the source itself
  localparam logic [CNT_W-1:0] FAST_XTAL_COUNT = 14'h1000;
  localparam logic [CNT_W-1:0] RC22_COUNT = 14'h0100;
  localparam logic [CNT_W-1:0] RC48_COUNT = 14'h0200;
  localparam logic [CNT_W-1:0] SLOW_COUNT = 14'h0001;

  // Stop detection windows
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FAST_FAIL_NS = 6400;
  localparam int unsigned SLOW_FAIL_NS = 102400;
  localparam logic [WD_W-1:0] FAST_FAIL_CYC =
    WD_W'(FAST_FAIL_NS / CLK_PERIOD_NS);
  localparam logic [WD_W-1:0] SLOW_FAIL_CYC =
    WD_W'(SLOW_FAIL_NS / CLK_PERIOD_NS);

  localparam logic [2:0] SYS_SEL_RST = 3'h3;
  localparam logic [2:0] TICK_SEL_RST = 3'h2;
  localparam logic [2:0] DIV_SRC_RST = 3'h3;

  typedef enum logic {PWR_RUN, PWR_SLEEP} ccc_pwr_t;

  typedef struct packed {
    logic fast_crystal_enable;
    logic slow_crystal_enable;
    logic fast_rc22_enable;
    logic slow_rc_enable;
    logic fast_rc48_enable;
    logic multiplier_power_down;
    logic multiplier_stable_count_select;
    logic multiplier_ref_rc22;
    logic [2:0] system_clock_select;
    logic [2:0] tick_clock_select;
    logic sleep_entry_enable;
    logic wfi_executed;
    logic wakeup_event;
    logic fast_fail_detect_enable;
    logic slow_fail_detect_enable;
    logic fast_crystal_fail_irq_enable;
    logic slow_crystal_fail_irq_enable;
    logic fast_fail_clear;
    logic slow_fail_clear;
    logic [2:0] divided_output_source;
    logic [3:0] divider_tap_select;
    logic divided_output_enable;
    logic divider_bypass;
  } ccc_ctrl_t;

  typedef struct packed {
    logic [5:0] stable;
    logic [5:0] osc_power_on;
    logic [2:0] system_clock_active;
    logic [2:0] tick_clock_active;
    logic fast_crystal_fail_flag;
    logic slow_crystal_fail_flag;
    logic fail_irq;
    logic in_power_down;
    logic divided_clock_pin;
  } ccc_stat_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0][CNT_W-1:0] cnt;
    logic [5:0] stable;
    logic [5:0] pwr_on;
    ccc_pwr_t pwr_state;
    logic [2:0] sys_sel;
    logic [2:0] sys_req_last;
    logic failover;
    logic [2:0] tick_sel;
    logic [WD_W-1:0] fast_wd;
    logic [WD_W-1:0] slow_wd;
    logic fast_fail;
    logic slow_fail;
    logic irq;
    logic [DIV_W-1:0] div_cnt;
    logic div_run;
    logic [2:0] div_src;
    logic div_pin;
  } ccc_state_t;

endpackage : ccc_pkg

// file: design/ccc_top.sv
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
#(
  parameter int unsigned PLL_COUNT_SHORT = 6144,
  parameter int unsigned PLL_COUNT_LONG = 12288
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [5:0] osc_in,
  input wire ccc_ctrl_t ctrl,
  output ccc_stat_t stat
);

  if (PLL_COUNT_SHORT < 1 || PLL_COUNT_LONG < 1 ||
      PLL_COUNT_SHORT >= (1 << CNT_W) || PLL_COUNT_LONG >= (1 << CNT_W))
  begin : g_bad_count
    $error("multiplier stable count out of range");
  end

  // Map a select code to a source index; codes without a source report
  // invalid so the active select simply holds.
  function automatic logic code_ok(input logic [2:0] code,
                                   input logic tick);
    code_ok = tick ? (code < 3'h5) : (code < 3'h6);
  endfunction : code_ok

  function automatic logic [2:0] code_src(input logic [2:0] code,
                                          input logic tick);
    logic [2:0] idx;
    idx = code;
    if (tick)
    begin
      case (code)
        3'h0: idx = SRC_FAST_XTAL;
        3'h1: idx = SRC_SLOW_XTAL;
        3'h2: idx = SRC_SLOW_RC;
        3'h3: idx = SRC_RC22;
        3'h4: idx = SRC_RC48;
        default: idx = SRC_SLOW_RC;
      endcase
    end
    code_src = idx;
  endfunction : code_src

  ccc_state_t r;
  ccc_state_t n;
  logic [5:0] rise;
  logic [5:0] edge_src;
  logic [5:0][CNT_W-1:0] thr;
  logic [CNT_W-1:0] cnt_inc;
  logic asleep_next;
  logic fast_stop;
  logic slow_stop;
  logic [2:0] sys_req;
  logic tap;
  logic src_lvl;
  logic div_out;

  // Oscillator edges are read only after the second sync stage
  assign rise = r.s2 & ~r.s3;

  always_comb
  begin
    n = r;
    cnt_inc = '0;
    n.s1 = osc_in;
    n.s2 = r.s1;
    n.s3 = r.s2;

    case (r.pwr_state)
      PWR_RUN:
        if (ctrl.sleep_entry_enable && ctrl.wfi_executed)
          n.pwr_state = PWR_SLEEP;
      PWR_SLEEP:
        if (ctrl.wakeup_event)
          n.pwr_state = PWR_RUN;
      default:
        n.pwr_state = PWR_RUN;
    endcase
    asleep_next = (n.pwr_state == PWR_SLEEP);

    n.pwr_on[SRC_FAST_XTAL] = ctrl.fast_crystal_enable && !asleep_next;
    n.pwr_on[SRC_RC22] = (ctrl.fast_rc22_enable ||
      ctrl.fast_fail_detect_enable) && !asleep_next;
    n.pwr_on[SRC_RC48] = ctrl.fast_rc48_enable && !asleep_next;
    // Slow sources never see the sleep term
    n.pwr_on[SRC_SLOW_XTAL] = ctrl.slow_crystal_enable;
    n.pwr_on[SRC_SLOW_RC] = ctrl.slow_rc_enable ||
      ctrl.slow_fail_detect_enable;
    n.pwr_on[SRC_MULT] = !ctrl.multiplier_power_down && !asleep_next &&
      (ctrl.multiplier_ref_rc22 ? n.pwr_on[SRC_RC22]
                                : n.pwr_on[SRC_FAST_XTAL]);

    thr[SRC_FAST_XTAL] = FAST_XTAL_COUNT;
    thr[SRC_SLOW_XTAL] = SLOW_COUNT;
    thr[SRC_SLOW_RC] = SLOW_COUNT;
    thr[SRC_RC22] = RC22_COUNT;
    thr[SRC_RC48] = RC48_COUNT;
    thr[SRC_MULT] = ctrl.multiplier_stable_count_select ?
      CNT_W'(PLL_COUNT_LONG) : CNT_W'(PLL_COUNT_SHORT);
    // Multiplier settles against its reference, not its own output
    edge_src = rise;
    edge_src[SRC_MULT] = ctrl.multiplier_ref_rc22 ?
      rise[SRC_RC22] : rise[SRC_FAST_XTAL];

    for (int i = 0; i < NSRC; i++)
    begin
      if (!n.pwr_on[i])
      begin
        n.cnt[i] = '0;
        n.stable[i] = 1'b0;
      end
      else if (!r.stable[i] && edge_src[i])
      begin
        cnt_inc = r.cnt[i] + 1'b1;
        n.cnt[i] = cnt_inc;
        n.stable[i] = (cnt_inc >= thr[i]);
      end
    end

    // Stop detectors: a stable crystal that shows no edge for the window
    fast_stop = 1'b0;
    if (ctrl.fast_fail_detect_enable && r.stable[SRC_FAST_XTAL])
    begin
      if (rise[SRC_FAST_XTAL])
        n.fast_wd = '0;
      else if (r.fast_wd != FAST_FAIL_CYC)
      begin
        n.fast_wd = r.fast_wd + 1'b1;
        fast_stop = (n.fast_wd == FAST_FAIL_CYC);
      end
    end
    else
      n.fast_wd = '0;
    slow_stop = 1'b0;
    if (ctrl.slow_fail_detect_enable && r.stable[SRC_SLOW_XTAL])
    begin
      if (rise[SRC_SLOW_XTAL])
        n.slow_wd = '0;
      else if (r.slow_wd != SLOW_FAIL_CYC)
      begin
        n.slow_wd = r.slow_wd + 1'b1;
        slow_stop = (n.slow_wd == SLOW_FAIL_CYC);
      end
    end
    else
      n.slow_wd = '0;

    // Set beats clear so a stop in the clearing cycle is kept
    n.fast_fail = fast_stop || (r.fast_fail && !ctrl.fast_fail_clear);
    n.slow_fail = slow_stop || (r.slow_fail && !ctrl.slow_fail_clear);
    n.irq = (n.fast_fail && ctrl.fast_crystal_fail_irq_enable) ||
      (n.slow_fail && ctrl.slow_crystal_fail_irq_enable);

    // Failover holds until software writes a new system select
    n.sys_req_last = ctrl.system_clock_select;
    if (ctrl.system_clock_select != r.sys_req_last)
      n.failover = 1'b0;
    if (fast_stop && (r.sys_sel == SRC_FAST_XTAL ||
        (r.sys_sel == SRC_MULT && !ctrl.multiplier_ref_rc22)))
      n.failover = 1'b1;
    sys_req = n.failover ? SRC_RC22 : ctrl.system_clock_select;
    // One register moves the select in a single step, only onto a
    // settled source, so the downstream mux never sees a half-state.
    if (code_ok(sys_req, 1'b0) && r.stable[code_src(sys_req, 1'b0)])
      n.sys_sel = code_src(sys_req, 1'b0);
    if (code_ok(ctrl.tick_clock_select, 1'b1) &&
        r.stable[code_src(ctrl.tick_clock_select, 1'b1)])
      n.tick_sel = ctrl.tick_clock_select;

    // Divider counts edges of the chosen source; bit N toggles at Fin/2^(N+1)
    if (r.div_run && rise[r.div_src])
      n.div_cnt = r.div_cnt + 1'b1;
    tap = r.div_cnt[ctrl.divider_tap_select];
    src_lvl = r.s2[r.div_src];
    div_out = ctrl.divider_bypass ? src_lvl : tap;
    if (ctrl.divided_output_enable)
      n.div_run = 1'b1;
    else if (r.div_run && !div_out)
      n.div_run = 1'b0;
    n.div_pin = n.div_run && div_out;
    // Source swaps only while the pin rests low, avoiding a runt pulse
    if (!r.div_pin && code_ok(ctrl.divided_output_source, 1'b0) &&
        r.stable[code_src(ctrl.divided_output_source, 1'b0)])
      n.div_src = code_src(ctrl.divided_output_source, 1'b0);
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.sys_sel <= SYS_SEL_RST;
      r.tick_sel <= TICK_SEL_RST;
      r.div_src <= DIV_SRC_RST;
    end
    else if (clk_en)
      r <= n;
  end

  assign stat.stable = r.stable;
  assign stat.osc_power_on = r.pwr_on;
  assign stat.system_clock_active = r.sys_sel;
  assign stat.tick_clock_active = r.tick_sel;
  assign stat.fast_crystal_fail_flag = r.fast_fail;
  assign stat.slow_crystal_fail_flag = r.slow_fail;
  assign stat.fail_irq = r.irq;
  assign stat.in_power_down = (r.pwr_state == PWR_SLEEP);
  assign stat.divided_clock_pin = r.div_pin;

  sleep_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && r.pwr_state == PWR_RUN && !ctrl.sleep_entry_enable
    |=> r.pwr_state == PWR_RUN)
    else $error("power-down entered without enable");
  sleep_power_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.pwr_state == PWR_SLEEP |-> !r.pwr_on[SRC_FAST_XTAL] &&
    !r.pwr_on[SRC_RC22] && !r.pwr_on[SRC_RC48])
    else $error("fast oscillator powered in sleep");
  fast_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(r.stable[SRC_FAST_XTAL]) |-> r.cnt[SRC_FAST_XTAL] ==
    FAST_XTAL_COUNT)
    else $error("fast crystal stable at wrong count");
  rc22_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(r.stable[SRC_RC22]) |-> r.cnt[SRC_RC22] == RC22_COUNT)
    else $error("rc22 stable at wrong count");
  disable_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && ctrl.multiplier_power_down |=> !r.stable[SRC_MULT])
    else $error("multiplier flag kept after power-down");
  sleep_flags_a: assert property (@(posedge mclk) disable iff (!reset_n)
    r.pwr_state == PWR_SLEEP |-> !r.stable[SRC_FAST_XTAL] &&
    !r.stable[SRC_RC22] && !r.stable[SRC_MULT])
    else $error("stable flag kept in sleep");
  select_stable_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && n.sys_sel != r.sys_sel |-> r.stable[n.sys_sel])
    else $error("system clock moved to unsettled source");
  failover_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(r.failover) |-> r.fast_fail &&
    (r.sys_sel == SRC_RC22 || !$past(r.stable[SRC_RC22])))
    else $error("failover without stop or switch");
  fail_irq_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && n.fast_fail && ctrl.fast_crystal_fail_irq_enable
    |=> r.irq)
    else $error("fail interrupt missing");
  force_rc_a: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && ctrl.fast_fail_detect_enable && n.pwr_state == PWR_RUN
    |=> r.pwr_on[SRC_RC22])
    else $error("detector did not force rc22 on");
  div_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !r.div_run |-> !r.div_pin)
    else $error("divided pin high while stopped");

endmodule : ccc_top

// file: dv/ccc_osc_model.sv
`timescale 1ns/1ps
module ccc_osc_model
(
  input wire logic [5:0] power_on,
  input wire logic [5:0] stop,
  output logic [5:0] osc,
  output int edges [6]
);
  // Mixed half periods; only 550 ns is a multiple of the 50 ns mclk half period
  localparam int HALF [6] = '{210, 550, 190, 560, 170, 130};
  logic [5:0] lvl = 6'h00;
  assign osc = lvl;
  for (genvar g = 0; g < 6; g++)
  begin : g_osc
    // A stopped or unpowered oscillator sits low, as a dead crystal does
    always
    begin
      #(HALF[g]);
      lvl[g] <= (power_on[g] === 1'b1) && !stop[g] ? ~lvl[g] : 1'b0;
    end
    always @(posedge lvl[g] or negedge power_on[g])
      edges[g] <= power_on[g] ? edges[g] + 1 : 0;
  end
endmodule : ccc_osc_model

// file: dv/chip_clock_controller_test.sv
`timescale 1ns/1ps
module chip_clock_controller_test;
  import ccc_pkg::*;
  // Short multiplier counts keep the run brief
  localparam int SHORT = 6;
  localparam int LONG = 12;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] stop = 6'h00;
  logic [5:0] osc_in;
  logic [5:0] seen = 6'h00;
  int edges [6];
  int at [6];
  int base;
  int p;
  int cycles = 0;
  int failures = 0;
  int samples_checked = 0;
  ccc_ctrl_t ctrl = '0;
  ccc_stat_t stat;

  ccc_top #(.PLL_COUNT_SHORT(SHORT), .PLL_COUNT_LONG(LONG)) DUT (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .osc_in(osc_in),
    .ctrl(ctrl),
    .stat(stat)
  );
  ccc_osc_model osc_model (
    .power_on(stat.osc_power_on),
    .stop(stop),
    .osc(osc_in),
    .edges(edges)
  );

  initial
    forever #50 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      failures++;
      results();
    end
  end

  // Source edges seen when each flag first rises; index 2 counts its reference
  always @(negedge mclk)
    for (int i = 0; i < 6; i++)
      if (stat.stable[i] === 1'b1 && !seen[i])
      begin
        seen[i] = 1'b1;
        at[i] = edges[i == 2 ? 4 : i];
      end

  task results;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task wait_stb(input int i, input int lim);
    for (int k = 0; k < lim && stat.stable[i] !== 1'b1; k++)
      @(negedge mclk);
    // Let the edge recorder settle before the count is judged
    tick(1);
  endtask : wait_stb

  task wait_pin(input logic v);
    for (int k = 0; k < 600 && stat.divided_clock_pin !== v; k++)
      @(negedge mclk);
  endtask : wait_pin

  task cnt_ok(input int i, input int n, input int d);
    check(seen[i] && at[i] >= n && at[i] <= n + d, 1'b1, "count");
  endtask : cnt_ok

  task per(input int exp);
    time t0;
    wait_pin(1'b0);
    wait_pin(1'b1);
    t0 = $time;
    wait_pin(1'b0);
    wait_pin(1'b1);
    p = int'($time - t0);
    check(p >= exp - 100 && p <= exp + 100, 1'b1, "pin period");
  endtask : per

  task t_reset;
    check(stat.stable, 6'h00, "stable");
    check(stat.system_clock_active, 3'h3, "sys");
    check(stat.tick_clock_active, 3'h2, "tick");
    check(stat.divided_clock_pin, 1'b0, "pin");
    $display("reset test done");
  endtask : t_reset

  task t_sources;
    ctrl.fast_crystal_enable = 1'b1;
    ctrl.slow_crystal_enable = 1'b1;
    ctrl.slow_rc_enable = 1'b1;
    ctrl.fast_rc22_enable = 1'b1;
    ctrl.fast_rc48_enable = 1'b1;
    tick(2);
    check(stat.osc_power_on, 6'h3b, "power on");
    check(stat.stable, 6'h00, "early stable");
    wait_stb(0, 20000);
    cnt_ok(0, 4096, 1);
    cnt_ok(1, 1, 1);
    cnt_ok(3, 1, 1);
    cnt_ok(4, 256, 1);
    cnt_ok(5, 512, 1);
    $display("source count test done");
  endtask : t_sources

  task t_mult(input logic sel, input int n);
    ctrl.multiplier_ref_rc22 = 1'b1;
    ctrl.multiplier_stable_count_select = sel;
    seen[2] = 1'b0;
    base = edges[4];
    ctrl.multiplier_power_down = 1'b0;
    wait_stb(2, 400);
    // A reference edge already in the sync flops may be counted too
    cnt_ok(2, base + n - 1, 2);
    $display("multiplier test done");
  endtask : t_mult

  task t_select;
    for (int c = 0; c < 7; c++)
    begin
      ctrl.system_clock_select = 3'(c);
      tick(40);
      check(stat.system_clock_active, c < 6 ? c : 5, "sys sel");
    end
    for (int c = 0; c < 6; c++)
    begin
      ctrl.tick_clock_select = 3'(c);
      tick(40);
      check(stat.tick_clock_active, c < 5 ? c : 4, "tick sel");
    end
    ctrl.system_clock_select = 3'h0;
    ctrl.fast_rc48_enable = 1'b0;
    tick(4);
    check(stat.stable[5], 1'b0, "rc48 off");
    ctrl.system_clock_select = 3'h5;
    tick(40);
    check(stat.system_clock_active, 3'h0, "unstable sel");
    $display("select test done");
  endtask : t_select

  task t_fail;
    ctrl.fast_rc22_enable = 1'b0;
    ctrl.fast_fail_detect_enable = 1'b1;
    ctrl.fast_crystal_fail_irq_enable = 1'b1;
    tick(2);
    check(stat.osc_power_on[4], 1'b1, "rc22 forced");
    stop[0] = 1'b1;
    tick(80);
    check(stat.fast_crystal_fail_flag, 1'b1, "fail flag");
    check(stat.fail_irq, 1'b1, "irq");
    check(stat.slow_crystal_fail_flag, 1'b0, "slow flag");
    tick(40);
    check(stat.system_clock_active, 3'h4, "failover");
    ctrl.fast_fail_clear = 1'b1;
    tick(2);
    ctrl.fast_fail_clear = 1'b0;
    check(stat.fast_crystal_fail_flag, 1'b0, "flag clear");
    check(stat.fail_irq, 1'b0, "irq clear");
    // Recovery by re-enable, switch back only once stable
    stop[0] = 1'b0;
    ctrl.fast_crystal_enable = 1'b0;
    tick(4);
    check(stat.stable[0], 1'b0, "xtal off");
    seen[0] = 1'b0;
    ctrl.fast_crystal_enable = 1'b1;
    wait_stb(0, 20000);
    cnt_ok(0, 4096, 1);
    ctrl.system_clock_select = 3'h4;
    tick(40);
    ctrl.system_clock_select = 3'h0;
    tick(40);
    check(stat.system_clock_active, 3'h0, "back to xtal");
    $display("fail test done");
  endtask : t_fail

  task t_sleep;
    ctrl.fast_fail_detect_enable = 1'b0;
    ctrl.fast_rc22_enable = 1'b1;
    ctrl.system_clock_select = 3'h3;
    ctrl.wfi_executed = 1'b1;
    tick(40);
    check(stat.in_power_down, 1'b0, "no enable");
    ctrl.sleep_entry_enable = 1'b1;
    tick(2);
    ctrl.wfi_executed = 1'b0;
    check(stat.in_power_down, 1'b1, "enter");
    check(stat.osc_power_on & 6'h35, 6'h00, "off");
    check(stat.stable & 6'h35, 6'h00, "flags");
    check(stat.osc_power_on[3], 1'b1, "rc on");
    check(stat.stable[1], 1'b1, "xtal on");
    tick(20);
    check(stat.in_power_down, 1'b1, "stay");
    seen[4] = 1'b0;
    ctrl.sleep_entry_enable = 1'b0;
    ctrl.wakeup_event = 1'b1;
    tick(2);
    ctrl.wakeup_event = 1'b0;
    check(stat.in_power_down, 1'b0, "wake");
    wait_stb(4, 2000);
    cnt_ok(4, 256, 1);
    $display("sleep test done");
  endtask : t_sleep

  task t_div;
    ctrl.divided_output_source = 3'h4;
    ctrl.divided_output_enable = 1'b1;
    per(680);
    ctrl.divider_tap_select = 4'h2;
    per(2720);
    ctrl.divider_bypass = 1'b1;
    per(340);
    ctrl.divider_bypass = 1'b0;
    ctrl.divider_tap_select = 4'h3;
    tick(100);
    ctrl.divided_output_enable = 1'b0;
    wait_pin(1'b0);
    p = 0;
    for (int k = 0; k < 200; k++)
    begin
      tick(1);
      p += stat.divided_clock_pin === 1'b1;
    end
    check(p, 0, "pin parked");
    $display("divider test done");
  endtask : t_div

  initial
  begin
    ctrl.multiplier_power_down = 1'b1;
    tick(16);
    t_reset();
    reset_n = 1'b1;
    t_sources();
    t_mult(1'b0, SHORT);
    ctrl.multiplier_power_down = 1'b1;
    tick(4);
    check(stat.stable[2], 1'b0, "mult off");
    t_mult(1'b1, LONG);
    t_select();
    t_fail();
    t_sleep();
    t_div();
    results();
  end
endmodule : chip_clock_controller_test
